/* File: core/regfile_pkg.sv */
// constants, offsets, reset values and states of the banked register file
//
// Contract
// RULE_01: 10h..17h are banked sfrs, bank from bank_selector low nibble
// RULE_02: unbanked sfrs reach one register whatever bank_selector holds
// RULE_03: ram 20h..ffh is banked, bank from bank_selector high nibble
// RULE_04: ram outside the banked range ignores bank_selector entirely
// RULE_05: small variant lacks ram banks 2 and 3; they read zero
// RULE_06: address 00h reads or writes the location held in pointer 01h
// RULE_07: status: selects in 7..4, flags in 3..0; selects reset to ones
// RULE_08: address 08h reads or writes the location held in pointer 09h
package regfile_pkg;

	// ****************************************
	// data memory map
	// ****************************************
	localparam logic [7:0] ADDR_IND0 = 8'h00;
	localparam logic [7:0] ADDR_PTR0 = 8'h01;
	localparam logic [7:0] ADDR_PC_LO = 8'h02;
	localparam logic [7:0] ADDR_PC_LATCH = 8'h03;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_T0CTL = 8'h05;
	localparam logic [7:0] ADDR_CPU_STAT = 8'h06;
	localparam logic [7:0] ADDR_INT_STAT = 8'h07;
	localparam logic [7:0] ADDR_IND1 = 8'h08;
	localparam logic [7:0] ADDR_PTR1 = 8'h09;
	localparam logic [7:0] ADDR_ACC = 8'h0a;
	localparam logic [7:0] ADDR_TIMER_LO = 8'h0b;
	localparam logic [7:0] ADDR_TIMER_HI = 8'h0c;
	localparam logic [7:0] ADDR_TBLL = 8'h0d;
	localparam logic [7:0] ADDR_TBLH = 8'h0e;
	localparam logic [7:0] ADDR_BANKSEL = 8'h0f;
	localparam logic [7:0] SFR_BANKED_LO = 8'h10;
	localparam logic [7:0] SFR_BANKED_HI = 8'h17;
	localparam logic [7:0] URAM_LO = 8'h1a;
	localparam logic [7:0] URAM_HI = 8'h1f;
	localparam logic [7:0] GPR_BANKED_LO = 8'h20;
	localparam logic [7:0] GPR_BANKED_HI = 8'hff;

	// ****************************************
	// storage shape
	// ****************************************
	localparam int GPR_DEPTH = 224;
	localparam int GPR_AW = 8;
	localparam int URAM_DEPTH = 6;
	localparam int URAM_AW = 3;
	localparam int GPR_BANKS = 4;
	localparam int SMALL_BANKS = 2;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BUS_IDX_LSB = 2;
	localparam int BUS_IDX_MSB = 9;
	localparam int CPU_STAT_INT_OFF = 4;
	localparam logic [7:0] T0CTL_MASK = 8'hfe;
	localparam logic [7:0] CPU_STAT_MASK = 8'h3f;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [3:0] RST_FSEL = 4'hf;
	localparam logic [7:0] RST_CPU_STAT_POR = 8'h3c;
	localparam logic [1:0] RST_CPU_STAT_TOP = 2'h3;

	// ****************************************
	// bus sequencer
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SFR = 2'b11,
		ST_ACK = 2'b01
	} bus_state_t;

endpackage

/* File: core/ram_bank.sv */
// one bank of flip-flop data ram, combinational read, single write port
module ram_bank #(
	parameter int DEPTH = 224,
	parameter int AW = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// write port
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [7:0] wdata_i,
	// read port
	input wire logic [AW-1:0] raddr_i,
	output logic [7:0] rdata_o
);

	logic [7:0] mem_r [DEPTH];

	// out of range index reads zero rather than undefined
	always_comb begin
		rdata_o = '0;
		if (int'(raddr_i) < DEPTH) begin
			rdata_o = mem_r[raddr_i];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else if (we_i && int'(waddr_i) < DEPTH) begin
			mem_r[waddr_i] <= wdata_i;
		end
	end

endmodule

/* File: core/banked_regfile.sv */
// banked data memory decoder with unbanked core registers on avalon-mm
//
// Design decision made here: the Avalon-MM interface to the registers.
module banked_regfile #(
	parameter bit LARGE_MEM = 1'b1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic other_reset_i,
	// avalon-mm slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// banked peripheral register port
	output logic [3:0] sfr_bank_o,
	output logic [2:0] sfr_addr_o,
	output logic sfr_rd_o,
	output logic sfr_wr_o,
	output logic [7:0] sfr_wdata_o,
	input wire logic [7:0] sfr_rdata_i
);

	// ****************************************
	// reset release
	// ****************************************
	logic rst_meta_r;
	logic rstn;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_r <= 1'b0;
			rstn <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rstn <= rst_meta_r;
		end
	end

	// ****************************************
	// core registers
	// ****************************************
	logic [7:0] ptr0_r;
	logic [7:0] ptr1_r;
	logic [7:0] pc_lo_r;
	logic [7:0] pc_latch_r;
	logic [3:0] fsel_r;
	logic [3:0] flags_r;
	logic [7:0] t0ctl_r;
	logic [7:0] cpu_stat_r;
	logic [7:0] int_stat_r;
	logic [7:0] acc_r;
	logic [7:0] timer_lo_r;
	logic [7:0] timer_hi_r;
	logic [7:0] tbll_r;
	logic [7:0] tblh_r;
	logic [7:0] bank_selector_r;

	// ****************************************
	// bus sequencer state
	// ****************************************
	regfile_pkg::bus_state_t state_r;
	regfile_pkg::bus_state_t state_nxt;
	logic [7:0] eff_r;
	logic [3:0] gbank_r;
	logic [7:0] wdata_r;
	logic wr_pend_r;

	// ****************************************
	// address resolution
	// ****************************************
	logic [7:0] bus_idx;
	logic [7:0] eff;
	logic req;
	logic eff_is_sfr;
	logic commit;

	assign bus_idx = avs_address_i[regfile_pkg::BUS_IDX_MSB:
		regfile_pkg::BUS_IDX_LSB];
	assign req = avs_read_i || avs_write_i;

	// indirect ports resolve one level only
	always_comb begin
		eff = bus_idx;
		// RULE_06: port 0 indirection
		if (bus_idx == regfile_pkg::ADDR_IND0) begin
			eff = ptr0_r;
		end
		// RULE_08: port 1 indirection
		if (bus_idx == regfile_pkg::ADDR_IND1) begin
			eff = ptr1_r;
		end
	end

	// RULE_01: banked sfr window
	assign eff_is_sfr = (eff >= regfile_pkg::SFR_BANKED_LO) &&
		(eff <= regfile_pkg::SFR_BANKED_HI);

	// write lands on the edge that sees waitrequest low
	assign commit = (state_r == regfile_pkg::ST_ACK) && wr_pend_r;

	// ****************************************
	// general purpose ram
	// ****************************************
	logic [7:0] gpr_rdata [regfile_pkg::GPR_BANKS];
	logic [7:0] gpr_raddr;
	logic [7:0] gpr_waddr;
	logic [7:0] uram_rdata;
	logic [7:0] uram_raddr;
	logic [7:0] uram_waddr;
	logic gpr_hit_w;
	logic uram_hit_w;

	assign gpr_raddr = eff - regfile_pkg::GPR_BANKED_LO;
	assign gpr_waddr = eff_r - regfile_pkg::GPR_BANKED_LO;
	assign uram_raddr = eff - regfile_pkg::URAM_LO;
	assign uram_waddr = eff_r - regfile_pkg::URAM_LO;
	assign gpr_hit_w = commit && (eff_r >= regfile_pkg::GPR_BANKED_LO);
	assign uram_hit_w = commit && (eff_r >= regfile_pkg::URAM_LO) &&
		(eff_r <= regfile_pkg::URAM_HI);

	for (genvar b = 0; b < regfile_pkg::GPR_BANKS; b++) begin : g_bank
		// RULE_05: upper banks only exist in the large variant
		if (LARGE_MEM || b < regfile_pkg::SMALL_BANKS) begin : g_on
			ram_bank #(
				.DEPTH(regfile_pkg::GPR_DEPTH),
				.AW(regfile_pkg::GPR_AW)
			) u_bank (
				.clk_i(clk_i),
				.rstn_i(rstn),
				// RULE_03: bank chosen by high nibble
				.we_i(gpr_hit_w && gbank_r == 4'(b)),
				.waddr_i(gpr_waddr),
				.wdata_i(wdata_r),
				.raddr_i(gpr_raddr),
				.rdata_o(gpr_rdata[b])
			);
		end else begin : g_off
			assign gpr_rdata[b] = '0;
		end
	end

	// RULE_04: unbanked ram, bank_selector not consulted
	ram_bank #(
		.DEPTH(regfile_pkg::URAM_DEPTH),
		.AW(regfile_pkg::URAM_AW)
	) u_uram (
		.clk_i(clk_i),
		.rstn_i(rstn),
		.we_i(uram_hit_w),
		.waddr_i(uram_waddr[regfile_pkg::URAM_AW-1:0]),
		.wdata_i(wdata_r),
		.raddr_i(uram_raddr[regfile_pkg::URAM_AW-1:0]),
		.rdata_o(uram_rdata)
	);

	// ****************************************
	// read mux
	// ****************************************
	logic [7:0] rd_val;
	logic [3:0] gbank;

	assign gbank = bank_selector_r[7:4];

	always_comb begin
		rd_val = '0;
		if (eff >= regfile_pkg::GPR_BANKED_LO) begin
			// RULE_05: missing or unbuilt banks read zero
			if (gbank < 4'(regfile_pkg::GPR_BANKS)) begin
				rd_val = gpr_rdata[gbank[1:0]];
			end
		end else if (eff >= regfile_pkg::URAM_LO &&
			eff <= regfile_pkg::URAM_HI) begin
			rd_val = uram_rdata;
		end else begin
			// RULE_02: unbanked sfrs decoded from address alone
			unique case (eff)
				regfile_pkg::ADDR_PTR0: rd_val = ptr0_r;
				regfile_pkg::ADDR_PC_LO: rd_val = pc_lo_r;
				regfile_pkg::ADDR_PC_LATCH: rd_val = pc_latch_r;
				regfile_pkg::ADDR_STATUS: rd_val = {fsel_r, flags_r};
				regfile_pkg::ADDR_T0CTL: rd_val = t0ctl_r;
				regfile_pkg::ADDR_CPU_STAT: rd_val = cpu_stat_r;
				regfile_pkg::ADDR_INT_STAT: rd_val = int_stat_r;
				regfile_pkg::ADDR_PTR1: rd_val = ptr1_r;
				regfile_pkg::ADDR_ACC: rd_val = acc_r;
				regfile_pkg::ADDR_TIMER_LO: rd_val = timer_lo_r;
				regfile_pkg::ADDR_TIMER_HI: rd_val = timer_hi_r;
				regfile_pkg::ADDR_TBLL: rd_val = tbll_r;
				regfile_pkg::ADDR_TBLH: rd_val = tblh_r;
				regfile_pkg::ADDR_BANKSEL: rd_val = bank_selector_r;
				// pointer aimed at a port, or unused holes: zero
				default: rd_val = '0;
			endcase
		end
	end

	// ****************************************
	// bus sequencer
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			regfile_pkg::ST_IDLE: begin
				if (req) begin
					// peripheral reads need a cycle to return data
					if (avs_read_i && eff_is_sfr) begin
						state_nxt = regfile_pkg::ST_SFR;
					end else begin
						state_nxt = regfile_pkg::ST_ACK;
					end
				end
			end
			regfile_pkg::ST_SFR: state_nxt = regfile_pkg::ST_ACK;
			regfile_pkg::ST_ACK: state_nxt = regfile_pkg::ST_IDLE;
			default: state_nxt = regfile_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			state_r <= regfile_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// request capture: address, bank and data frozen at acceptance
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			eff_r <= '0;
			gbank_r <= '0;
			wdata_r <= '0;
			wr_pend_r <= 1'b0;
		end else if (state_r == regfile_pkg::ST_IDLE && req) begin
			eff_r <= eff;
			gbank_r <= gbank;
			wdata_r <= avs_writedata_i[7:0];
			wr_pend_r <= avs_write_i && avs_byteenable_i[0];
		end else if (state_r == regfile_pkg::ST_ACK) begin
			wr_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= '0;
		end else begin
			avs_waitrequest_o <= (state_nxt != regfile_pkg::ST_ACK);
			if (state_r == regfile_pkg::ST_IDLE && avs_read_i) begin
				avs_readdata_o <= {24'h000000, rd_val};
			end else if (state_r == regfile_pkg::ST_SFR) begin
				avs_readdata_o <= {24'h000000, sfr_rdata_i};
			end
		end
	end

	// ****************************************
	// banked peripheral port
	// ****************************************
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			sfr_bank_o <= '0;
			sfr_addr_o <= '0;
			sfr_rd_o <= 1'b0;
			sfr_wr_o <= 1'b0;
			sfr_wdata_o <= '0;
		end else begin
			sfr_rd_o <= 1'b0;
			sfr_wr_o <= 1'b0;
			if (state_r == regfile_pkg::ST_IDLE && req && eff_is_sfr) begin
				// RULE_01: low nibble picks the peripheral bank
				sfr_bank_o <= bank_selector_r[3:0];
				sfr_addr_o <= eff[2:0];
				sfr_wdata_o <= avs_writedata_i[7:0];
				sfr_rd_o <= avs_read_i;
				sfr_wr_o <= avs_write_i && avs_byteenable_i[0];
			end
		end
	end

	// ****************************************
	// core register writes
	// ****************************************
	function automatic logic hit(input logic [7:0] a);
		hit = commit && (eff_r == a);
	endfunction

	// pointers, pc, accumulator, timer and table bytes
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			ptr0_r <= regfile_pkg::RST_ZERO;
			ptr1_r <= regfile_pkg::RST_ZERO;
			pc_lo_r <= regfile_pkg::RST_ZERO;
			pc_latch_r <= regfile_pkg::RST_ZERO;
			acc_r <= regfile_pkg::RST_ZERO;
			timer_lo_r <= regfile_pkg::RST_ZERO;
			timer_hi_r <= regfile_pkg::RST_ZERO;
			tbll_r <= regfile_pkg::RST_ZERO;
			tblh_r <= regfile_pkg::RST_ZERO;
		end else if (other_reset_i) begin
			// holding latch and data registers survive a warm reset
			pc_lo_r <= regfile_pkg::RST_ZERO;
			tbll_r <= regfile_pkg::RST_ZERO;
			tblh_r <= regfile_pkg::RST_ZERO;
		end else begin
			if (hit(regfile_pkg::ADDR_PTR0)) ptr0_r <= wdata_r;
			if (hit(regfile_pkg::ADDR_PTR1)) ptr1_r <= wdata_r;
			if (hit(regfile_pkg::ADDR_PC_LO)) pc_lo_r <= wdata_r;
			if (hit(regfile_pkg::ADDR_PC_LATCH)) pc_latch_r <= wdata_r;
			if (hit(regfile_pkg::ADDR_ACC)) acc_r <= wdata_r;
			if (hit(regfile_pkg::ADDR_TIMER_LO)) timer_lo_r <= wdata_r;
			if (hit(regfile_pkg::ADDR_TIMER_HI)) timer_hi_r <= wdata_r;
			if (hit(regfile_pkg::ADDR_TBLL)) tbll_r <= wdata_r;
			if (hit(regfile_pkg::ADDR_TBLH)) tblh_r <= wdata_r;
		end
	end

	// arithmetic status
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			// RULE_07: function selects reset to ones
			fsel_r <= regfile_pkg::RST_FSEL;
			flags_r <= '0;
		end else if (other_reset_i) begin
			fsel_r <= regfile_pkg::RST_FSEL;
		end else if (hit(regfile_pkg::ADDR_STATUS)) begin
			// RULE_07: selects high, flags low
			fsel_r <= wdata_r[7:4];
			flags_r <= wdata_r[3:0];
		end
	end

	// timer control, cpu status, interrupt status, bank select
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			t0ctl_r <= regfile_pkg::RST_ZERO;
			cpu_stat_r <= regfile_pkg::RST_CPU_STAT_POR;
			int_stat_r <= regfile_pkg::RST_ZERO;
			bank_selector_r <= regfile_pkg::RST_ZERO;
		end else if (other_reset_i) begin
			t0ctl_r <= regfile_pkg::RST_ZERO;
			cpu_stat_r[5:4] <= regfile_pkg::RST_CPU_STAT_TOP;
			int_stat_r <= regfile_pkg::RST_ZERO;
			bank_selector_r <= regfile_pkg::RST_ZERO;
		end else begin
			if (hit(regfile_pkg::ADDR_T0CTL)) begin
				t0ctl_r <= wdata_r & regfile_pkg::T0CTL_MASK;
			end
			// only the global interrupt disable is software writable
			if (hit(regfile_pkg::ADDR_CPU_STAT)) begin
				cpu_stat_r[regfile_pkg::CPU_STAT_INT_OFF] <=
					wdata_r[regfile_pkg::CPU_STAT_INT_OFF];
			end
			if (hit(regfile_pkg::ADDR_INT_STAT)) int_stat_r <= wdata_r;
			if (hit(regfile_pkg::ADDR_BANKSEL)) bank_selector_r <= wdata_r;
		end
	end

endmodule

/* File: sim/banked_regfile_props.sv */
// concurrent checks on the ports of the banked register file
module banked_regfile_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic other_reset_i,
	// avalon-mm slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// banked peripheral register port
	input wire logic [3:0] sfr_bank_o,
	input wire logic [2:0] sfr_addr_o,
	input wire logic sfr_rd_o,
	input wire logic sfr_wr_o,
	input wire logic [7:0] sfr_wdata_o,
	input wire logic [7:0] sfr_rdata_i
);
	// ****************************************
	// helpers
	// ****************************************
	logic [7:0] idx;
	logic req;
	assign idx = avs_address_i[9:2];
	assign req = avs_read_i | avs_write_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// ****************************************
	// properties
	// ****************************************
	sfr_rd_path_a: assert property (
		sfr_rd_o |=> !avs_waitrequest_o &&
		avs_readdata_o == {24'h000000, $past(sfr_rdata_i)})
		else $error("peripheral read data not returned");
	sfr_wr_ack_a: assert property (
		sfr_wr_o |-> !avs_waitrequest_o && avs_write_i &&
		sfr_wdata_o == avs_writedata_i[7:0])
		else $error("peripheral write not tied to bus write");
	sfr_rd_cause_a: assert property (
		sfr_rd_o |-> avs_read_i && avs_waitrequest_o)
		else $error("peripheral read without bus read");
	unbanked_local_a: assert property (
		$rose(req) && idx inside {[8'h01:8'h07], [8'h09:8'h0f]}
		|=> !avs_waitrequest_o && !sfr_rd_o && !sfr_wr_o)
		else $error("unbanked register not answered locally");
	spare_zero_a: assert property (
		$rose(avs_read_i) && idx inside {8'h18, 8'h19}
		|=> !avs_waitrequest_o && avs_readdata_o == 32'h00000000)
		else $error("excluded register did not read zero");
	ram_local_a: assert property (
		$rose(avs_read_i) && idx >= 8'h20
		|=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("banked ram read not answered in one cycle");
	uram_local_a: assert property (
		$rose(avs_write_i) && idx inside {[8'h1a:8'h1f]}
		|=> !avs_waitrequest_o && !sfr_wr_o)
		else $error("unbanked ram write not local");
	ind0_ack_a: assert property (
		$rose(req) && idx == 8'h00 |-> ##[1:2] !avs_waitrequest_o)
		else $error("indirect port 0 not answered");
	ind1_ack_a: assert property (
		$rose(req) && idx == 8'h08 |-> ##[1:2] !avs_waitrequest_o)
		else $error("indirect port 1 not answered");
	ack_pulse_a: assert property (
		!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000
		##1 avs_waitrequest_o)
		else $error("ack not a single cycle or upper data set");
endmodule

bind banked_regfile banked_regfile_props props_u (.*);

/* File: sim/banked_regfile_tb.sv */
// self-checking bench for the banked register file decoder
module banked_regfile_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// signals
	// ****************************************
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic other_reset_i = 1'b0;
	logic [9:0] avs_address_i = 10'h000;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h00000000;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic [31:0] small_rdata;
	logic avs_waitrequest_o;
	logic [3:0] sfr_bank_o;
	logic [2:0] sfr_addr_o;
	logic sfr_rd_o;
	logic sfr_wr_o;
	logic [7:0] sfr_wdata_o;
	logic [7:0] sfr_rdata_i;
	logic [7:0] cyc = 8'h00;
	logic [14:0] last_wr = 15'h0000;
	logic [7:0] q;
	logic [7:0] qs;
	int err_total = 0;
	int n_checks = 0;

	always #2 clk_i = ~clk_i;
	// idle peripheral data changes every cycle, so stale data cannot pass
	assign sfr_rdata_i = sfr_rd_o ? {sfr_bank_o, 1'b1, sfr_addr_o} : cyc;
	always @(posedge clk_i) begin
		cyc <= cyc + 8'h01;
		if (sfr_wr_o) begin
			last_wr <= {sfr_bank_o, sfr_addr_o, sfr_wdata_o};
		end
	end

	// ****************************************
	// devices: full and small memory
	// ****************************************
	banked_regfile #(.LARGE_MEM(1'b1)) dut_u (.clk_i(clk_i),
		.resetn_i(resetn_i), .other_reset_i(other_reset_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .sfr_bank_o(sfr_bank_o),
		.sfr_addr_o(sfr_addr_o), .sfr_rd_o(sfr_rd_o), .sfr_wr_o(sfr_wr_o),
		.sfr_wdata_o(sfr_wdata_o), .sfr_rdata_i(sfr_rdata_i));
	banked_regfile #(.LARGE_MEM(1'b0)) small_u (.clk_i(clk_i),
		.resetn_i(resetn_i), .other_reset_i(other_reset_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(small_rdata),
		.avs_waitrequest_o(), .sfr_bank_o(), .sfr_addr_o(), .sfr_rd_o(),
		.sfr_wr_o(), .sfr_wdata_o(), .sfr_rdata_i(sfr_rdata_i));

	// ****************************************
	// tasks
	// ****************************************
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, s, e);
		end
	endtask

	// one avalon transfer; the request holds until waitrequest is seen low
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= {a, 2'b00};
		avs_write_i <= w;
		avs_read_i <= ~w;
		avs_writedata_i <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 16);
		q = avs_readdata_o[7:0];
		qs = small_rdata[7:0];
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n >= 16) begin
			err_total++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 8'h00);
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < 16; i++) begin
			rd(i[7:0]);
			chk(q, i == 4 ? 8'hf0 : (i == 6 ? 8'h3c : 8'h00));
		end
		wr(8'h02, 8'h12);
		wr(8'h0a, 8'h34);
		wr(8'h0f, 8'h11);
		wr(8'h04, 8'h05);
		@(posedge clk_i);
		other_reset_i <= 1'b1;
		@(posedge clk_i);
		other_reset_i <= 1'b0;
		rd(8'h02);
		chk(q, 8'h00);
		rd(8'h0a);
		chk(q, 8'h34);
		rd(8'h04);
		chk(q, 8'hf5);
		for (int b = 0; b < 16; b++) begin
			wr(8'h0f, {4'h0, b[3:0]});
			rd(8'h10 + {5'h00, b[2:0]});
			chk(q, {b[3:0], 1'b1, b[2:0]});
		end
		wr(8'h0f, 8'h07);
		wr(8'h16, 8'h99);
		wr(8'h0a, 8'h77);
		chk({1'b0, last_wr[14:8]}, 8'h3e);
		chk(last_wr[7:0], 8'h99);
		wr(8'h0f, 8'h35);
		rd(8'h0a);
		chk(q, 8'h77);
		rd(8'h18);
		chk(q, 8'h00);
		wr(8'h40, 8'hc3);
		rd(8'h40);
		chk(q, 8'hc3);
		chk(qs, 8'h00);
		wr(8'h0f, 8'h00);
		wr(8'h20, 8'ha0);
		wr(8'h1a, 8'h5c);
		wr(8'h0f, 8'h10);
		wr(8'h20, 8'hb0);
		rd(8'h1a);
		chk(q, 8'h5c);
		rd(8'h20);
		chk(qs, 8'hb0);
		wr(8'h0f, 8'h00);
		rd(8'h20);
		chk(q, 8'ha0);
		rd(8'h40);
		chk(q, 8'h00);
		wr(8'h01, 8'h30);
		wr(8'h00, 8'h66);
		rd(8'h30);
		chk(q, 8'h66);
		wr(8'h30, 8'h67);
		rd(8'h00);
		chk(q, 8'h67);
		wr(8'h0f, 8'h04);
		wr(8'h01, 8'h12);
		rd(8'h00);
		chk(q, 8'h4a);
		wr(8'h09, 8'h1b);
		wr(8'h08, 8'h42);
		rd(8'h1b);
		chk(q, 8'h42);
		wr(8'h09, 8'h00);
		rd(8'h08);
		chk(q, 8'h00);
		avs_byteenable_i <= 4'he;
		wr(8'h0a, 8'h55);
		avs_byteenable_i <= 4'hf;
		rd(8'h0a);
		chk(q, 8'h77);
		complete_run();
	end
endmodule
